// [ated_detector.sv]
// adaptive tooth edge detector: calibration, peak/valley tracking, switching
// assumes sample_in is a new sample each cycle, supply_ok comes from an async
// supply monitor pin, reverse_dir from same-clock direction logic
`timescale 1ns/10ps

// Function
// - output off (high) from power-on
// - forward: high over tooth, rises at leading
// - reverse rotation inverts output polarity
// - first edge may be silent, second switches
// - first falling edge uses calibrated thresholds
// - undervoltage forces output off, ignores signal
// - power-up measures amplitude, sets constant gain
// - peak and valley trackers reference comparator
// - thresholds at 30 and 70 percent
// - forty percent hysteresis independent of gap
// - thresholds recomputed continuously while running
// - thresholds from previous two edges' data
module ated_detector
    import ated_pkg::*;
#(
    parameter int CAL_LEN = CAL_SAMPLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [SAMPLE_W-1:0] sample_in, // raw differential sample
    input wire logic supply_ok, // async supply-good, low below supply_lockout_level
    input wire logic reverse_dir, // same-clock direction flag
    output logic tooth_out, // open-collector level, high is off
    output logic calibrated // high once gain is fixed
);
    ated_state_s st; // registered state
    ated_state_s nx; // next state

    logic [SAMPLE_W-1:0] norm; // gain-scaled sample
    logic [SAMPLE_W+GAIN_W-1:0] prod; // full product before scaling
    logic [SAMPLE_W-1:0] span; // reference span
    logic [SAMPLE_W-1:0] ref_pk; // combined peak of two previous edges
    logic [SAMPLE_W-1:0] ref_vl; // combined valley of two previous edges
    logic [SAMPLE_W+7:0] low_sc; // scaled span fractions
    logic [SAMPLE_W+7:0] high_sc;
    logic supply_good; // filtered supply flag
    logic raw_level; // switching decision before polarity
    logic [SAMPLE_W-1:0] cal_span; // measured calibration amplitude
    logic [SAMPLE_W+GAIN_W-1:0] gain_full; // calibration gain before clipping
    logic [GAIN_W-1:0] cal_gain; // calibration gain clipped to the gain word
    logic [SAMPLE_W+GAIN_W-1:0] seed_pk; // calibrated peak before clipping
    logic [SAMPLE_W+GAIN_W-1:0] seed_vl; // calibrated valley before clipping

    // gain scaling, saturating so a large gap cannot wrap the sample
    always_comb begin
        prod = sample_in * st.gain;
        if (prod[SAMPLE_W+GAIN_W-1:SAMPLE_W+8] != '0) begin
            norm = '1;
        end else begin
            norm = prod[SAMPLE_W+7:8];
        end
    end

    // next-state logic
    always_comb begin
        nx = st;
        // a change counts once second and third stage agree
        nx.good_sync = {st.good_sync[1:0], supply_ok};
        // the filtered flag moves only when stages two and three agree, so a
        // glitch caught by the first stage alone never reaches the output
        if (st.good_sync[1] == st.good_sync[2]) begin
            nx.sup_good = st.good_sync[2];
        end
        cal_span = st.track.peak - st.track.valley;
        // gain that maps the measured span onto the target span; a very small
        // span would overflow the gain word, so the gain clips at full scale
        if (cal_span != '0) begin
            gain_full = (24'(TARGET_SPAN) << 8) / 24'(cal_span);
        end else begin
            gain_full = 24'(st.gain);
        end
        cal_gain = (gain_full[SAMPLE_W+GAIN_W-1:GAIN_W] != '0) ? '1 : gain_full[GAIN_W-1:0];
        // seeds are scaled like the running sample and clip the same way, so a
        // large offset cannot wrap a reference around to the other rail
        seed_pk = (24'(st.track.peak) * 24'(cal_gain)) >> 8;
        seed_vl = (24'(st.track.valley) * 24'(cal_gain)) >> 8;
        // references merge the two preceding edges, so run-out is followed
        ref_pk = (st.prev.peak > st.prev2.peak) ? st.prev.peak : st.prev2.peak;
        ref_vl = (st.prev.valley < st.prev2.valley) ? st.prev.valley : st.prev2.valley;
        span = (ref_pk > ref_vl) ? ref_pk - ref_vl : '0;
        low_sc = 20'(span) * 20'(LOW_PCT) / 20'd100;
        high_sc = 20'(span) * 20'(HIGH_PCT) / 20'd100; // gap is 40% of span
        // switching works on the magnet level; direction only flips the pin
        raw_level = st.out;
        case (st.phase)
            ATED_CAL: begin
                // park the magnet level at the off state for the present direction,
                // so the pin stays off when running starts until a real crossing
                nx.out = OUT_OFF ^ reverse_dir;
                nx.reverse = reverse_dir;
                // track raw amplitude, then pick gain that hits the target span
                if (sample_in > st.track.peak) nx.track.peak = sample_in;
                if (sample_in < st.track.valley) nx.track.valley = sample_in;
                nx.cal_cnt = st.cal_cnt + 11'h001;
                if (32'(st.cal_cnt) == CAL_LEN - 1) begin
                    nx.phase = ATED_RUN;
                    nx.gain = cal_gain;
                    // seed references from the calibration so the first edge is exact
                    nx.prev.peak = (seed_pk[SAMPLE_W+GAIN_W-1:SAMPLE_W] != '0) ? '1
                        : seed_pk[SAMPLE_W-1:0];
                    nx.prev.valley = (seed_vl[SAMPLE_W+GAIN_W-1:SAMPLE_W] != '0) ? '1
                        : seed_vl[SAMPLE_W-1:0];
                    nx.prev2 = nx.prev;
                    nx.track = '{peak: PEAK_RST, valley: VALLEY_RST};
                end
            end
            ATED_RUN: begin
                // trackers follow the normalised signal
                if (norm > st.track.peak) nx.track.peak = norm;
                if (norm < st.track.valley) nx.track.valley = norm;
                nx.th_low = ref_vl + low_sc[SAMPLE_W-1:0];
                nx.th_high = ref_vl + high_sc[SAMPLE_W-1:0];
                // the internal level follows the magnet; hysteresis holds in between.
                // under lockout nothing switches: a forced level fighting the signal
                // would look like an edge every cycle and wash out the edge history
                if (supply_good) begin
                    if (raw_level && norm < st.th_low) begin
                        nx.out = ~st.out;
                    end else if (!raw_level && norm > st.th_high) begin
                        nx.out = ~st.out;
                    end
                    if (nx.out != st.out) begin
                        // edge: shift history, restart trackers
                        nx.prev2 = st.prev;
                        nx.prev = st.track;
                        nx.track = '{peak: norm, valley: norm};
                        if (st.edges != 2'h3) nx.edges = st.edges + 2'h1;
                    end
                end
                // a direction change flips the pin at once, with no edge of its own
                nx.reverse = reverse_dir;
            end
            default: nx.phase = ATED_CAL;
        endcase
        // supply below the lockout level: force off, no signal reaction
        if (!supply_good) begin
            nx.out = OUT_OFF ^ reverse_dir;
        end
    end

    // filtered supply flag, kept in the state so it changes on agreement only
    always_comb begin
        supply_good = st.sup_good;
    end

    // state register, off state at reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{phase: ATED_CAL, cal_cnt: 11'h000, gain: GAIN_ONE,
                    track: '{peak: PEAK_RST, valley: VALLEY_RST},
                    prev: '{peak: PEAK_RST, valley: PEAK_RST},
                    prev2: '{peak: PEAK_RST, valley: PEAK_RST},
                    th_low: 12'h000, th_high: 12'hFFF, out: OUT_OFF, edges: 2'h0,
                    good_sync: 3'h0, sup_good: 1'b0, reverse: 1'b0};
        end else begin
            st <= nx;
        end
    end

    // outputs from flops; output level is internal level xor direction
    // the pin is held off during calibration and under lockout whatever the level
    logic out_q;
    logic cal_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= OUT_OFF;
            cal_q <= 1'b0;
        end else begin
            out_q <= (supply_good && nx.phase == ATED_RUN) ? (nx.out ^ nx.reverse) : OUT_OFF;
            cal_q <= (nx.phase == ATED_RUN);
        end
    end
    assign tooth_out = out_q;
    assign calibrated = cal_q;

    // assertions: they watch the registered state and the pin one cycle after
    // the decision, so a slip in the pipeline shows up here first
    off_at_lockout_a: assert property (@(posedge clk) disable iff (!rstn)
        !st.good_sync[1] && !st.good_sync[2] |-> ##2 tooth_out == OUT_OFF)
        else $error("output not off under lockout");
    off_in_cal_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_CAL && nx.phase == ATED_CAL |=> tooth_out == OUT_OFF)
        else $error("output left off state before calibration");
    hyst_gap_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN |=> st.th_high >= st.th_low)
        else $error("thresholds out of order");
    cal_done_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_CAL && 32'(st.cal_cnt) == CAL_LEN - 1 |=> st.phase == ATED_RUN)
        else $error("calibration did not end");
    track_peak_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && nx.out == st.out && norm > st.track.peak
        |=> st.track.peak == $past(norm))
        else $error("peak tracker missed sample");
    switch_low_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && supply_good && raw_level && norm < st.th_low
        && reverse_dir == st.reverse |=> st.out != $past(st.out))
        else $error("no switch below lower threshold");
    hist_shift_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && nx.out != st.out && supply_good
        |=> st.prev2 == $past(st.prev))
        else $error("edge history not shifted");
    pol_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && supply_good && nx.phase == ATED_RUN
        |=> tooth_out == $past(nx.out ^ nx.reverse))
        else $error("output polarity wrong");
    sync_agree_a: assert property (@(posedge clk) disable iff (!rstn)
        st.sup_good != $past(st.sup_good) |-> $past(st.good_sync[1]) == $past(st.good_sync[2]))
        else $error("supply flag moved before stages agreed");
    edge_count_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && supply_good && nx.out != st.out && st.edges != 2'h3
        |=> st.edges == $past(st.edges) + 2'h1)
        else $error("edge not counted");
    lock_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
        st.phase == ATED_RUN && !supply_good |=> st.prev == $past(st.prev))
        else $error("edge history moved under lockout");
endmodule

// [ated_pkg.sv]
// package for the adaptive tooth edge detector: widths, fractions, states
// assumes samples arrive as unsigned words on the block clock
package ated_pkg;
    // sample width and calibration length
    localparam int SAMPLE_W = 12;
    localparam int CAL_SAMPLES = 1024;
    // gain word: unsigned q4.8, unity is 1.0
    localparam int GAIN_W = 12;
    localparam logic [GAIN_W-1:0] GAIN_ONE = 12'h100;
    // normalised target span after gain
    localparam logic [SAMPLE_W-1:0] TARGET_SPAN = 12'h800;
    // threshold fractions in percent
    localparam int LOW_PCT = 30;
    localparam int HIGH_PCT = 70;
    // output states: off reads high
    localparam logic OUT_OFF = 1'b1;
    // reset values of the trackers
    localparam logic [SAMPLE_W-1:0] PEAK_RST = 12'h000;
    localparam logic [SAMPLE_W-1:0] VALLEY_RST = 12'hFFF;

    // top-level phase
    typedef enum logic [1:0] {
        ATED_CAL = 2'b00,
        ATED_RUN = 2'b01
    } ated_phase_e;

    // span references of one edge
    typedef struct packed {
        logic [SAMPLE_W-1:0] peak;
        logic [SAMPLE_W-1:0] valley;
    } ated_span_s;

    // state of the detector, apart from the output flops out_q and cal_q
    typedef struct packed {
        ated_phase_e phase;
        logic [10:0] cal_cnt;
        logic [GAIN_W-1:0] gain;
        ated_span_s track;
        ated_span_s prev;
        ated_span_s prev2;
        logic [SAMPLE_W-1:0] th_low;
        logic [SAMPLE_W-1:0] th_high;
        logic out;
        logic [1:0] edges;
        logic [2:0] good_sync;
        logic sup_good;
        logic reverse;
    } ated_state_s;
endpackage

// [ated_speed_ctrl.sv]
// speed controller model: counts falling and rising edges of the tooth line
// assumes the tooth line is a settled level sampled on the block clock
`timescale 1ns/10ps
module ated_speed_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tooth, // level from the detector, high is off
    output logic [7:0] falls, // count of high to low steps
    output logic [7:0] rises // count of low to high steps
);
    logic last; // previous level, starts at the pulled-up off level
    // edge counting; a real controller times these, counts suffice here
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last <= 1'b1;
            falls <= 8'h00;
            rises <= 8'h00;
        end else begin
            last <= tooth;
            if (last && !tooth) begin
                falls <= falls + 8'h01;
            end
            if (!last && tooth) begin
                rises <= rises + 8'h01;
            end
        end
    end
endmodule

// [ated_tb.sv]
// self-checking bench for the tooth edge detector with a short calibration
// assumes a 4 ns clock; levels 0x400/0xC00 keep the gain at unity
`timescale 1ns/10ps
module tb;
    import ated_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [SAMPLE_W-1:0] sample_in = 12'h400;
    logic supply_ok = 1'b1;
    logic reverse_dir = 1'b0;
    logic tooth_out, calibrated;
    logic [7:0] falls, rises;
    int failures = 0;
    int checked = 0;
    // short calibration keeps the run brief
    ated_detector #(.CAL_LEN(16)) dut (.clk(clk), .rstn(rstn), .sample_in(sample_in),
        .supply_ok(supply_ok), .reverse_dir(reverse_dir), .tooth_out(tooth_out),
        .calibrated(calibrated));
    ated_speed_ctrl ctrl (.clk(clk), .rstn(rstn), .tooth(tooth_out), .falls(falls),
        .rises(rises));
    // free-running clock
    always #2 clk = ~clk;
    // hold one level long enough to pass the two-cycle answer
    task automatic hold(input logic [11:0] v);
        @(negedge clk) sample_in = v;
        repeat (8) @(negedge clk);
    endtask
    task automatic chk(input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic t_cal();
        int n;
        chk(1'b1, tooth_out);
        chk(1'b0, calibrated);
        @(negedge clk) rstn = 1'b1;
        hold(12'h400);
        chk(1'b1, tooth_out);
        hold(12'hC00);
        // bounded wait for the gain to settle
        for (n = 0; n < 8 && calibrated !== 1'b1; n++) @(negedge clk);
        chk(1'b1, calibrated);
        $display("test calibration done");
    endtask
    task automatic t_fwd();
        hold(12'hC00);
        chk(1'b1, tooth_out);
        hold(12'h400);
        chk(1'b0, tooth_out);
        chk8(8'h01, falls);
        hold(12'h800);
        chk(1'b0, tooth_out);
        hold(12'hC00);
        chk(1'b1, tooth_out);
        hold(12'h700);
        chk(1'b1, tooth_out);
        hold(12'h600);
        chk(1'b0, tooth_out);
        hold(12'h400);
        hold(12'h980);
        chk(1'b0, tooth_out);
        hold(12'hA00);
        chk(1'b1, tooth_out);
        chk8(8'h02, falls);
        chk8(8'h02, rises);
        $display("test forward done");
    endtask
    task automatic t_track();
        repeat (4) begin
            hold(12'hE00);
            hold(12'h600);
        end
        hold(12'hA00);
        chk(1'b0, tooth_out);
        hold(12'hE00);
        chk(1'b1, tooth_out);
        $display("test tracking done");
    endtask
    task automatic t_uv();
        hold(12'h600);
        supply_ok = 1'b0;
        hold(12'h600);
        chk(1'b1, tooth_out);
        hold(12'hE00);
        hold(12'h600);
        chk(1'b1, tooth_out);
        supply_ok = 1'b1;
        hold(12'hE00);
        $display("test lockout done");
    endtask
    task automatic t_rev();
        reverse_dir = 1'b1;
        hold(12'hE00);
        chk(1'b0, tooth_out);
        hold(12'h600);
        chk(1'b1, tooth_out);
        $display("test reverse done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence, reset held for two cycles
    initial begin
        repeat (2) @(posedge clk);
        t_cal();
        t_fwd();
        t_track();
        t_uv();
        t_rev();
        results();
    end
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #40000;
        failures++;
        results();
    end
endmodule
